/* File: aoc_defines.svh */
// Constants of the output-stage configuration and fault register bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef AOC_DEFINES_SVH
`define AOC_DEFINES_SVH

// =====================================================================
// Register indices (byte address is four times the index)
`define AOC_IDX_OUTPUT_CFG     8'h06
`define AOC_IDX_RESERVED_SLOT  8'h07
`define AOC_IDX_FAULT_CFG      8'h08
`define AOC_ADDR_W             12

// =====================================================================
// Output stage configuration fields
`define AOC_BRIDGE_BIT         7
`define AOC_RATE_MSB           6
`define AOC_RATE_LSB           4
`define AOC_GAIN_MSB           3
`define AOC_GAIN_LSB           2
`define AOC_MONO_SRC_BIT       1
`define AOC_RSVD0_BIT          0
`define AOC_OUTPUT_CFG_RESET   8'h51
`define AOC_GAIN_RESERVED      2'h3

// =====================================================================
// Fault configuration and status fields
`define AOC_THR_MSB            5
`define AOC_THR_LSB            4
`define AOC_CLOCK_ERROR_FLAG_BIT           3
`define AOC_OCE_BIT            2
`define AOC_DCE_BIT            1
`define AOC_OTE_BIT            0
`define AOC_THR_RESET          2'h0
`define AOC_NUM_LATCHED        3

// =====================================================================
// AXI4-Lite responses
`define AOC_RESP_OKAY          2'h0
`define AOC_RESP_SLVERR        2'h2

`endif

/* File: aoc_pkg.sv */
// Types of the output-stage configuration and fault register bank.
// Assumes aoc_defines.svh is on the include path.
`default_nettype none

`include "aoc_defines.svh"

package aoc_pkg;

  // ===================================================================
  // Modes and codes
  typedef enum logic [0:0] {
    AOC_STEREO_BRIDGE = 1'b0,
    AOC_MONO_PARALLEL = 1'b1
  } aoc_bridge_e;

  typedef enum logic [1:0] {
    AOC_GAIN_19P2 = 2'b00,
    AOC_GAIN_22P6 = 2'b01,
    AOC_GAIN_25P0 = 2'b10,
    AOC_GAIN_RSVD = 2'b11
  } aoc_gain_e;

  // ===================================================================
  // Bus slave state
  typedef struct packed {
    logic                     aw_got;
    logic [`AOC_ADDR_W-1:0]   awaddr;
    logic                     w_got;
    logic [31:0]              wdata;
    logic [3:0]               wstrb;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
  } aoc_axil_s;

endpackage

`default_nettype wire

/* File: aoc_reg_if.sv */
// Register access carrier between the bus slave and the register bank.
// Assumes one clock; read lookup is combinational.
`default_nettype none

interface aoc_reg_if;
  logic       wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic       wr_hit;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;
  logic       rd_hit;

  modport slave (
    output wr_en,
    output wr_idx,
    output wr_data,
    input  wr_hit,
    output rd_idx,
    input  rd_data,
    input  rd_hit
  );

  modport bank (
    input  wr_en,
    input  wr_idx,
    input  wr_data,
    output wr_hit,
    input  rd_idx,
    output rd_data,
    output rd_hit
  );
endinterface

`default_nettype wire

/* File: aoc_axil_slave.sv */
// AXI4-Lite slave that turns bus transfers into byte register accesses.
// Assumes one write and one read outstanding at most, 32-bit data.
`default_nettype none

`include "aoc_defines.svh"

module aoc_axil_slave
  import aoc_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`AOC_ADDR_W-1:0] s_axil_awaddr,
  input  wire logic                   s_axil_awvalid,
  output logic                        s_axil_awready,
  input  wire logic [31:0]            s_axil_wdata,
  input  wire logic [3:0]             s_axil_wstrb,
  input  wire logic                   s_axil_wvalid,
  output logic                        s_axil_wready,
  output logic [1:0]                  s_axil_bresp,
  output logic                        s_axil_bvalid,
  input  wire logic                   s_axil_bready,
  input  wire logic [`AOC_ADDR_W-1:0] s_axil_araddr,
  input  wire logic                   s_axil_arvalid,
  output logic                        s_axil_arready,
  output logic [31:0]                 s_axil_rdata,
  output logic [1:0]                  s_axil_rresp,
  output logic                        s_axil_rvalid,
  input  wire logic                   s_axil_rready,
  aoc_reg_if.slave                    regs
);

  aoc_axil_s st_q;
  aoc_axil_s st_d;
  logic      do_write;

  // ===================================================================
  // Handshake outputs
  assign s_axil_awready = !st_q.aw_got && !st_q.bvalid;
  assign s_axil_wready  = !st_q.w_got && !st_q.bvalid;
  assign s_axil_arready = !st_q.rvalid;
  assign s_axil_bvalid  = st_q.bvalid;
  assign s_axil_bresp   = st_q.bresp;
  assign s_axil_rvalid  = st_q.rvalid;
  assign s_axil_rdata   = st_q.rdata;
  assign s_axil_rresp   = st_q.rresp;

  // Register port: write once both halves are held
  assign do_write      = st_q.aw_got && st_q.w_got && !st_q.bvalid;
  assign regs.wr_en    = do_write && st_q.wstrb[0] && (st_q.awaddr[1:0] == 2'h0);
  assign regs.wr_idx   = st_q.awaddr[9:2];
  assign regs.wr_data  = st_q.wdata[7:0];
  assign regs.rd_idx   = s_axil_araddr[9:2];

  // Next state of the slave
  always_comb begin
    st_d = st_q;
    if (s_axil_awvalid && s_axil_awready) begin
      st_d.aw_got = 1'b1;
      st_d.awaddr = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_axil_wready) begin
      st_d.w_got = 1'b1;
      st_d.wdata = s_axil_wdata;
      st_d.wstrb = s_axil_wstrb;
    end
    if (do_write) begin
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = (regs.wr_hit && st_q.awaddr[`AOC_ADDR_W-1:10] == '0) ?
                    `AOC_RESP_OKAY : `AOC_RESP_SLVERR;
    end
    if (st_q.bvalid && s_axil_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.rvalid && s_axil_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axil_arvalid && s_axil_arready) begin
      st_d.rvalid = 1'b1;
      if (regs.rd_hit && s_axil_araddr[`AOC_ADDR_W-1:10] == '0) begin
        st_d.rdata = {24'h00_0000, regs.rd_data};
        st_d.rresp = `AOC_RESP_OKAY;
      end else begin
        st_d.rdata = 32'h0000_0000;
        st_d.rresp = `AOC_RESP_SLVERR;
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

`default_nettype wire

/* File: aoc_fault_latch.sv */
// Sticky fault flags, one per protection event.
// Assumes events and the clear pulse are synchronous to aclk.
`default_nettype none

module aoc_fault_latch #(
  parameter int NUM = 3
) (
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic [NUM-1:0] fault_event,
  input  wire logic           clear_pulse,
  output logic      [NUM-1:0] fault_q
);

  logic [NUM-1:0] fault_d;

  // Per flag: an event in the clearing cycle still sets
  for (genvar i = 0; i < NUM; i++) begin : g_flag
    assign fault_d[i] = fault_event[i] || (fault_q[i] && !clear_pulse);
  end

  // Flag register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_q <= '0;
    end else begin
      fault_q <= fault_d;
    end
  end

endmodule

`default_nettype wire

/* File: aoc_output_config_fault_regs.sv */
// Output-stage configuration and fault register bank of a class-D amplifier.
// Assumes protection events and the clock checker arrive synchronous to aclk,
// and that software reaches the bank over AXI4-Lite.
//
// Contract
// - Bridge enable bit 7 picks stereo bridge (0) or mono parallel (1).
// - Rate field 6:4 selects 6,8,10,12,14,16,20,24 times frame clock.
// - In double speed mode the switching multiple is halved.
// - Gain code 3:2 selects 19.2, 22.6, 25 dBV; code 11 never used.
// - In mono mode bit 1 picks right (0) or left (1) input channel.
// - Fault register holds threshold field 5:4 and four read-only flags.
// - Threshold codes give full, 75, 50 and 25 percent of nominal.
// - Clock error flag follows the clock checker and clears by itself.
// - Latched faults halt output until shutdown input is toggled.
`default_nettype none

`include "aoc_defines.svh"

module aoc_output_config_fault_regs
  import aoc_pkg::*;
#(
  parameter int SAMPLE_W = 24
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite register port
  input  wire logic [`AOC_ADDR_W-1:0] s_axil_awaddr,
  input  wire logic                   s_axil_awvalid,
  output logic                        s_axil_awready,
  input  wire logic [31:0]            s_axil_wdata,
  input  wire logic [3:0]             s_axil_wstrb,
  input  wire logic                   s_axil_wvalid,
  output logic                        s_axil_wready,
  output logic [1:0]                  s_axil_bresp,
  output logic                        s_axil_bvalid,
  input  wire logic                   s_axil_bready,
  input  wire logic [`AOC_ADDR_W-1:0] s_axil_araddr,
  input  wire logic                   s_axil_arvalid,
  output logic                        s_axil_arready,
  output logic [31:0]                 s_axil_rdata,
  output logic [1:0]                  s_axil_rresp,
  output logic                        s_axil_rvalid,
  input  wire logic                   s_axil_rready,
  // Audio samples in and speaker channels out
  input  wire logic                   sample_valid,
  input  wire logic [SAMPLE_W-1:0]    sample_left,
  input  wire logic [SAMPLE_W-1:0]    sample_right,
  output logic                        spk_valid,
  output logic [SAMPLE_W-1:0]         spk_a,
  output logic [SAMPLE_W-1:0]         spk_b,
  // Mode inputs and protection events
  input  wire logic                   double_speed_mode,
  input  wire logic                   clocks_invalid,
  input  wire logic                   overcurrent_event,
  input  wire logic                   dc_error_event,
  input  wire logic                   overtemp_event,
  input  wire logic                   speaker_shutdown_n,
  // Configuration driven to the output stage
  output logic                        parallel_bridge_enable,
  output logic                        mono_source_select,
  output logic [4:0]                  switching_multiple,
  output logic [1:0]                  analog_gain_code,
  output logic [1:0]                  overcurrent_threshold,
  output logic                        amp_run,
  output logic                        clock_error_flag,
  output logic                        overcurrent_flag,
  output logic                        output_dc_error_flag,
  output logic                        overtemp_flag
);

  // ===================================================================
  // State of the bank
  typedef struct packed {
    logic [7:0]          out_cfg;
    logic [1:0]          oc_thr;
    logic                clk_err;
    logic                sd_n_prev;
    logic [4:0]          sw_mult;
    logic                run;
    logic                spk_valid;
    logic [SAMPLE_W-1:0] spk_a;
    logic [SAMPLE_W-1:0] spk_b;
  } aoc_bank_s;

  aoc_bank_s st_q;
  aoc_bank_s st_d;

  aoc_reg_if regs ();

  logic [`AOC_NUM_LATCHED-1:0] fault_event;
  logic [`AOC_NUM_LATCHED-1:0] fault_q;
  logic                        sd_release;
  logic [4:0]                  rate_mult;
  logic [7:0]                  fault_reg;
  aoc_bridge_e                 bridge_mode;
  aoc_gain_e                   gain_wr;

  // ===================================================================
  // Bus slave
  aoc_axil_slave u_axil (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .s_axil_awaddr  (s_axil_awaddr),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_wdata   (s_axil_wdata),
    .s_axil_wstrb   (s_axil_wstrb),
    .s_axil_wvalid  (s_axil_wvalid),
    .s_axil_wready  (s_axil_wready),
    .s_axil_bresp   (s_axil_bresp),
    .s_axil_bvalid  (s_axil_bvalid),
    .s_axil_bready  (s_axil_bready),
    .s_axil_araddr  (s_axil_araddr),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_rdata   (s_axil_rdata),
    .s_axil_rresp   (s_axil_rresp),
    .s_axil_rvalid  (s_axil_rvalid),
    .s_axil_rready  (s_axil_rready),
    .regs           (regs.slave)
  );

  // ===================================================================
  // Latched protection flags
  assign fault_event = {overcurrent_event, dc_error_event, overtemp_event};

  // Shutdown released after being held low
  assign sd_release = !st_q.sd_n_prev && speaker_shutdown_n;

  aoc_fault_latch #(
    .NUM (`AOC_NUM_LATCHED)
  ) u_faults (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .fault_event (fault_event),
    .clear_pulse (sd_release),
    .fault_q     (fault_q)
  );

  // ===================================================================
  // Decoded configuration
  assign bridge_mode = aoc_bridge_e'(st_q.out_cfg[`AOC_BRIDGE_BIT]);
  assign gain_wr     = aoc_gain_e'(regs.wr_data[`AOC_GAIN_MSB:`AOC_GAIN_LSB]);

  // Rate code to frame-clock multiple
  always_comb begin
    unique case (st_q.out_cfg[`AOC_RATE_MSB:`AOC_RATE_LSB])
      3'b000: rate_mult = 5'd6;
      3'b001: rate_mult = 5'd8;
      3'b010: rate_mult = 5'd10;
      3'b011: rate_mult = 5'd12;
      3'b100: rate_mult = 5'd14;
      3'b101: rate_mult = 5'd16;
      3'b110: rate_mult = 5'd20;
      3'b111: rate_mult = 5'd24;
    endcase
  end

  // Fault register image, reserved bits read zero
  always_comb begin
    fault_reg                             = 8'h00;
    fault_reg[`AOC_THR_MSB:`AOC_THR_LSB]  = st_q.oc_thr;
    fault_reg[`AOC_CLOCK_ERROR_FLAG_BIT]              = st_q.clk_err;
    fault_reg[`AOC_OCE_BIT]               = fault_q[2];
    fault_reg[`AOC_DCE_BIT]               = fault_q[1];
    fault_reg[`AOC_OTE_BIT]               = fault_q[0];
  end

  // ===================================================================
  // Register decode for the bus slave
  always_comb begin
    regs.rd_hit  = 1'b1;
    regs.rd_data = 8'h00;
    unique case (regs.rd_idx)
      `AOC_IDX_OUTPUT_CFG:    regs.rd_data = st_q.out_cfg;
      `AOC_IDX_RESERVED_SLOT: regs.rd_data = 8'h00;
      `AOC_IDX_FAULT_CFG:     regs.rd_data = fault_reg;
      default:                regs.rd_hit  = 1'b0;
    endcase
  end

  // Write decode: mapped slots answer, unmapped ones are refused
  assign regs.wr_hit = (regs.wr_idx == `AOC_IDX_OUTPUT_CFG) ||
                       (regs.wr_idx == `AOC_IDX_RESERVED_SLOT) ||
                       (regs.wr_idx == `AOC_IDX_FAULT_CFG);

  // ===================================================================
  // Next state of the bank
  always_comb begin
    st_d           = st_q;
    st_d.sd_n_prev = speaker_shutdown_n;
    // Live clock checker, no latching
    st_d.clk_err   = clocks_invalid;

    // Software writes
    if (regs.wr_en && regs.wr_idx == `AOC_IDX_OUTPUT_CFG) begin
      st_d.out_cfg[`AOC_BRIDGE_BIT] = regs.wr_data[`AOC_BRIDGE_BIT];
      st_d.out_cfg[`AOC_RATE_MSB:`AOC_RATE_LSB] =
        regs.wr_data[`AOC_RATE_MSB:`AOC_RATE_LSB];
      if (gain_wr != AOC_GAIN_RSVD) begin
        st_d.out_cfg[`AOC_GAIN_MSB:`AOC_GAIN_LSB] = gain_wr;
      end
      st_d.out_cfg[`AOC_MONO_SRC_BIT] = regs.wr_data[`AOC_MONO_SRC_BIT];
      st_d.out_cfg[`AOC_RSVD0_BIT]    = regs.wr_data[`AOC_RSVD0_BIT];
    end
    if (regs.wr_en && regs.wr_idx == `AOC_IDX_FAULT_CFG) begin
      st_d.oc_thr = regs.wr_data[`AOC_THR_MSB:`AOC_THR_LSB];
    end

    // Halved multiple in double speed mode
    st_d.sw_mult = double_speed_mode ? {1'b0, rate_mult[4:1]} : rate_mult;

    // Output stage runs only with clean clocks, no fault, no shutdown
    st_d.run = speaker_shutdown_n && !clocks_invalid && !(|fault_event) &&
               !(|fault_q && !sd_release);

    // Channel routing, silenced while halted
    st_d.spk_valid = sample_valid && st_q.run;
    if (sample_valid) begin
      if (!st_q.run) begin
        st_d.spk_a = '0;
        st_d.spk_b = '0;
      end else if (bridge_mode == AOC_MONO_PARALLEL) begin
        st_d.spk_a = st_q.out_cfg[`AOC_MONO_SRC_BIT] ? sample_left : sample_right;
        st_d.spk_b = st_q.out_cfg[`AOC_MONO_SRC_BIT] ? sample_left : sample_right;
      end else begin
        st_d.spk_a = sample_left;
        st_d.spk_b = sample_right;
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q           <= '0;
      st_q.out_cfg   <= `AOC_OUTPUT_CFG_RESET;
      st_q.oc_thr    <= `AOC_THR_RESET;
      st_q.sd_n_prev <= 1'b1;
      st_q.sw_mult   <= 5'd16;
    end else begin
      st_q <= st_d;
    end
  end

  // ===================================================================
  // Outputs, all from flip-flops
  assign parallel_bridge_enable = st_q.out_cfg[`AOC_BRIDGE_BIT];
  assign mono_source_select     = st_q.out_cfg[`AOC_MONO_SRC_BIT];
  assign switching_multiple     = st_q.sw_mult;
  assign analog_gain_code       = st_q.out_cfg[`AOC_GAIN_MSB:`AOC_GAIN_LSB];
  assign overcurrent_threshold  = st_q.oc_thr;
  assign amp_run                = st_q.run;
  assign clock_error_flag       = st_q.clk_err;
  assign overcurrent_flag       = fault_q[2];
  assign output_dc_error_flag   = fault_q[1];
  assign overtemp_flag          = fault_q[0];
  assign spk_valid              = st_q.spk_valid;
  assign spk_a                  = st_q.spk_a;
  assign spk_b                  = st_q.spk_b;

endmodule

`default_nettype wire

/* File: aoc_regs_checker.sv */
// Concurrent checks on the ports of the output-stage configuration bank.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none

module aoc_regs_checker #(
  parameter int SAMPLE_W = 24
) (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                s_axil_awvalid,
  input wire logic                s_axil_awready,
  input wire logic                s_axil_wvalid,
  input wire logic                s_axil_wready,
  input wire logic                s_axil_bvalid,
  input wire logic                sample_valid,
  input wire logic [SAMPLE_W-1:0] sample_left,
  input wire logic [SAMPLE_W-1:0] sample_right,
  input wire logic                spk_valid,
  input wire logic [SAMPLE_W-1:0] spk_a,
  input wire logic [SAMPLE_W-1:0] spk_b,
  input wire logic                double_speed_mode,
  input wire logic                clocks_invalid,
  input wire logic                overcurrent_event,
  input wire logic                speaker_shutdown_n,
  input wire logic                parallel_bridge_enable,
  input wire logic                mono_source_select,
  input wire logic [4:0]          switching_multiple,
  input wire logic [1:0]          analog_gain_code,
  input wire logic                amp_run,
  input wire logic                clock_error_flag,
  input wire logic                overcurrent_flag,
  input wire logic                output_dc_error_flag,
  input wire logic                overtemp_flag
);
  logic sd_prev_q;
  logic rel_w;

  // ===================================================================
  // Shutdown release detection
  always_ff @(posedge aclk) begin
    sd_prev_q <= speaker_shutdown_n;
  end
  assign rel_w = speaker_shutdown_n && !sd_prev_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ===================================================================
  // Bus handshakes
  sequence s_wr_both;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
  endsequence
  a_wr_resp_time: assert property (s_wr_both |-> ##2 s_axil_bvalid)
    else $error("write response late");
  a_aw_blocked: assert property (s_axil_bvalid |-> !s_axil_awready)
    else $error("address taken while response pending");

  // ===================================================================
  // Configuration and routing
  a_gain_legal: assert property (analog_gain_code != 2'h3)
    else $error("reserved gain code reached output");
  a_rate_single: assert property (!$past(double_speed_mode) |->
    switching_multiple inside {5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h14, 5'h18})
    else $error("single speed multiple illegal");
  a_rate_double: assert property ($past(aresetn) && $past(double_speed_mode) |->
    switching_multiple inside {5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0A, 5'h0C})
    else $error("double speed multiple illegal");
  a_stereo_route: assert property (spk_valid && !$past(parallel_bridge_enable) |->
    spk_a == $past(sample_left) && spk_b == $past(sample_right))
    else $error("stereo routing wrong");
  a_mono_route: assert property (spk_valid && $past(parallel_bridge_enable) |->
    spk_a == spk_b && spk_a == ($past(mono_source_select) ? $past(sample_left) : $past(sample_right)))
    else $error("mono routing wrong");

  // ===================================================================
  // Fault flags
  a_clk_err_track: assert property ($past(aresetn) |->
    clock_error_flag == $past(clocks_invalid))
    else $error("clock error flag not tracking");
  a_oce_sets: assert property (overcurrent_event |=> overcurrent_flag)
    else $error("overcurrent flag not set");
  a_oce_clear: assert property ($fell(overcurrent_flag) |-> $past(rel_w))
    else $error("overcurrent flag cleared without release");
  a_dce_clear: assert property ($fell(output_dc_error_flag) |-> $past(rel_w))
    else $error("dc flag cleared without release");
  a_halt_on_fault: assert property (overcurrent_flag || output_dc_error_flag
    || overtemp_flag || clock_error_flag |-> !amp_run)
    else $error("output running during fault");
  a_spk_cause: assert property (spk_valid |-> $past(sample_valid && amp_run))
    else $error("speaker sample without cause");
endmodule

bind aoc_output_config_fault_regs aoc_regs_checker #(.SAMPLE_W(SAMPLE_W)) i_aoc_regs_checker (.*);

`default_nettype wire

/* File: aoc_output_config_fault_regs_tb.sv */
// Self-checking bench for the output-stage configuration and fault bank.
// Assumes design and checker files are compiled before this one.
`default_nettype none

module aoc_output_config_fault_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] OCFG = 12'h018, RSV = 12'h01C, FLT = 12'h020, NOMAP = 12'h024;
  localparam logic [23:0] L = 24'h12_3456, R = 24'h65_4321;

  logic        aclk = '0, aresetn = '0;
  logic [11:0] s_axil_awaddr = '0, s_axil_araddr = '0;
  logic [31:0] s_axil_wdata = '0, s_axil_rdata;
  logic [3:0]  s_axil_wstrb = 4'h1;
  logic        s_axil_awvalid = '0, s_axil_wvalid = '0, s_axil_bready = '0;
  logic        s_axil_arvalid = '0, s_axil_rready = '0, sample_valid = '0;
  logic        s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [1:0]  s_axil_bresp, s_axil_rresp, analog_gain_code, overcurrent_threshold;
  logic [23:0] sample_left = L, sample_right = R, spk_a, spk_b;
  logic        double_speed_mode = '0, clocks_invalid = '0, overcurrent_event = '0;
  logic        dc_error_event = '0, overtemp_event = '0, speaker_shutdown_n = '1;
  logic        spk_valid, parallel_bridge_enable, mono_source_select, amp_run;
  logic        clock_error_flag, overcurrent_flag, output_dc_error_flag, overtemp_flag;
  logic [4:0]  switching_multiple;
  logic [4:0]  mult [8] = '{5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h14, 5'h18};
  int          error_cnt = 0, cmp_count = 0, cyc = 0;

  aoc_output_config_fault_regs i_aoc_output_config_fault_regs (.*);

  // ===================================================================
  // Clock and hang guard
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ===================================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Bus write, both halves offered together
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw, w;
    @(posedge aclk);
    aw = 1'h1;
    w = 1'h1;
    s_axil_awaddr <= a;
    s_axil_wdata <= {24'h00_0000, d};
    s_axil_awvalid <= 1'h1;
    s_axil_wvalid <= 1'h1;
    s_axil_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (aw && s_axil_awready === 1'h1) begin
        aw = 1'h0;
        s_axil_awvalid <= 1'h0;
      end
      if (w && s_axil_wready === 1'h1) begin
        w = 1'h0;
        s_axil_wvalid <= 1'h0;
      end
    end while (s_axil_bvalid !== 1'h1);
    s_axil_bready <= 1'h0;
    chk("bresp", 32'(er), 32'(s_axil_bresp));
  endtask

  // Bus read with data and response compare
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    logic ar;
    @(posedge aclk);
    ar = 1'h1;
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'h1;
    s_axil_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (ar && s_axil_arready === 1'h1) begin
        ar = 1'h0;
        s_axil_arvalid <= 1'h0;
      end
    end while (s_axil_rvalid !== 1'h1);
    s_axil_rready <= 1'h0;
    chk("rdata", 32'(e), s_axil_rdata);
    chk("rresp", 32'(er), 32'(s_axil_rresp));
  endtask

  // One sample pair through the output path
  task automatic smp(input logic ev, input logic [23:0] ea, input logic [23:0] eb);
    @(posedge aclk);
    sample_valid <= 1'h1;
    @(posedge aclk);
    sample_valid <= 1'h0;
    @(posedge aclk);
    chk("spk_valid", 32'(ev), 32'(spk_valid));
    chk("spk_a", 32'(ea), 32'(spk_a));
    chk("spk_b", 32'(eb), 32'(spk_b));
  endtask

  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ===================================================================
  // Main sequence
  initial begin
    tick(6);
    aresetn <= 1'h1;
    rd(OCFG, 8'h51, 2'h0);
    chk("multiple", 32'h10, 32'(switching_multiple));
    rd(FLT, 8'h00, 2'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(OCFG, {1'h0, 3'(i), 4'h1}, 2'h0);
      tick(2);
      chk("multiple", 32'(mult[i]), 32'(switching_multiple));
      double_speed_mode <= 1'h1;
      tick(2);
      chk("half", 32'(mult[i] / 2), 32'(switching_multiple));
      double_speed_mode <= 1'h0;
    end
    $display("test rates done");
    for (int g = 0; g < 3; g++) begin
      wr(OCFG, {4'h5, 2'(g), 2'h1}, 2'h0);
      rd(OCFG, {4'h5, 2'(g), 2'h1}, 2'h0);
      chk("gain", 32'(g), 32'(analog_gain_code));
    end
    wr(OCFG, 8'hDD, 2'h0);
    rd(OCFG, 8'hD9, 2'h0);
    $display("test gain done");
    for (int k = 0; k < 3; k++) begin
      wr(OCFG, (k == 0) ? 8'h51 : ((k == 1) ? 8'hD1 : 8'hD3), 2'h0);
      tick(1);
      smp(1'h1, (k == 1) ? R : L, (k == 2) ? L : R);
    end
    $display("test routing done");
    wr(RSV, 8'hFF, 2'h0);
    rd(RSV, 8'h00, 2'h0);
    wr(NOMAP, 8'hFF, 2'h2);
    rd(NOMAP, 8'h00, 2'h2);
    rd(OCFG, 8'hD3, 2'h0);
    $display("test reserved done");
    for (int t = 0; t < 4; t++) begin
      wr(FLT, {2'h3, 2'(t), 4'hF}, 2'h0);
      rd(FLT, {2'h0, 2'(t), 4'h0}, 2'h0);
      chk("threshold", 32'(t), 32'(overcurrent_threshold));
    end
    $display("test threshold done");
    clocks_invalid <= 1'h1;
    tick(2);
    chk("clk_flag", 32'h1, 32'(clock_error_flag));
    chk("run", 32'h0, 32'(amp_run));
    rd(FLT, 8'h38, 2'h0);
    clocks_invalid <= 1'h0;
    tick(2);
    rd(FLT, 8'h30, 2'h0);
    chk("run", 32'h1, 32'(amp_run));
    $display("test clock error done");
    for (int k = 0; k < 3; k++) begin
      {overcurrent_event, dc_error_event, overtemp_event} <= 3'h4 >> k;
      tick(1);
      {overcurrent_event, dc_error_event, overtemp_event} <= 3'h0;
      smp(1'h0, 24'h00_0000, 24'h00_0000);
      speaker_shutdown_n <= 1'h0;
      tick(2);
      rd(FLT, {4'h3, 4'(3'h4 >> k)}, 2'h0);
      speaker_shutdown_n <= 1'h1;
      tick(2);
      rd(FLT, 8'h30, 2'h0);
      chk("run", 32'h1, 32'(amp_run));
    end
    $display("test faults done");
    report_and_stop();
  end
endmodule

`default_nettype wire
